// file: dio_pkg.sv
// Constants for the discrete I/O register map block.
`default_nettype none

package dio_pkg;
   localparam int unsigned CHAN_NUM = 4;
   localparam logic [7:0]  FN_READ_COILS     = 8'h01;
   localparam logic [7:0]  FN_READ_INPUTS    = 8'h02;
   localparam logic [7:0]  FN_READ_HOLDING   = 8'h03;
   localparam logic [7:0]  FN_READ_INPUT_REG = 8'h04;
   localparam logic [7:0]  FN_FORCE_COIL     = 8'h05;
   localparam logic [7:0]  FN_PRESET_REG     = 8'h06;
   localparam logic [7:0]  FN_FORCE_COILS    = 8'h0F;
   localparam logic [7:0]  FN_PRESET_REGS    = 8'h10;
   localparam logic [7:0]  EXC_NONE          = 8'h00;
   localparam logic [7:0]  EXC_ILLEGAL_FUNC  = 8'h01;
   localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
   localparam logic [7:0]  EXC_ILLEGAL_VALUE = 8'h03;
   localparam logic [15:0] OUTPUT_COIL_CH0     = 16'h0000;
   localparam logic [15:0] OUTPUT_COIL_CH3     = 16'h0003;
   localparam logic [15:0] INPUT_STATUS_CH0    = 16'h0000;
   localparam logic [15:0] PACKED_INPUT_STATES = 16'h0000;
   localparam logic [15:0] OUTPUT_GROUP_REG    = 16'h0000;
   localparam logic [16:0] ADDR_LIMIT          = 17'h00004;
   localparam logic [15:0] COIL_ON_VALUE       = 16'hFF00;
   localparam logic [15:0] COIL_OFF_VALUE      = 16'h0000;
   localparam logic [15:0] GROUP_VALID_MASK    = 16'h000F;
   localparam logic [3:0]  COIL_RESET          = 4'h0;
endpackage : dio_pkg

`default_nettype wire

// file: dio_map.sv
// Discrete output coils, discrete inputs and packed input register of the I/O map.
//
// Functional notes
// - One global option picks coil access or grouped register access, never both.
// - Coil references work only while coil access is enabled.
// - The grouped output register works only while coil access is disabled.
// - A forced one turns the output on, a forced zero turns it off.
// - All outputs reset to off and are always actively driven.
// - Input inversion never changes how coil values drive outputs.
// - Coil reads pack the start coil in the LSB, unused bits zero.
// - Input reads pack thresholded states, start channel in the LSB, ascending.
// - Data bits beyond the requested inputs read as zero.
// - An input above the high threshold reads one, below it zero.
// - Packed input register holds channels 0 to 3 in bits 0 to 3, rest zero.
// - Packed input bits follow live pins, including a driven tandem output.
// - With inversion enabled the reported input states are complemented.
// - A grouped register write updates all four outputs at once.
// - Unsupported function gives exception 01, bad register value exception 03.
`timescale 1ns/1ps
`default_nettype none

module dio_map
   import dio_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        coil_mode_en,
   input  wire logic        input_invert_en,
   input  wire logic [3:0]  input_above_thr,
   output var  logic [3:0]  output_on,
   input  wire logic        req_valid,
   input  wire logic [7:0]  req_func,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_qty,
   input  wire logic [15:0] req_wdata,
   output var  logic        rsp_valid,
   output var  logic [7:0]  rsp_exc,
   output var  logic [15:0] rsp_data
);

   // Mask of the lowest qty channels; qty is already range checked.
   function automatic logic [3:0] chan_mask(input logic [15:0] qty);
      logic [3:0] m;
      m = 4'h0;
      for (int i = 0; i < CHAN_NUM; i++)
      begin
         if (qty > 16'(i))
         begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // True when a run of qty references starting at addr lies within the channels.
   function automatic logic span_ok(input logic [15:0] addr, input logic [15:0] qty);
      logic [16:0] last;
      last = {1'b0, addr} + {1'b0, qty};
      return (qty != 16'h0000) && (last <= ADDR_LIMIT);
   endfunction

   // True when a one-register request names exactly the given reference.
   function automatic logic one_reg_ok(input logic [15:0] addr, input logic [15:0] qty,
                                       input logic [15:0] ref_addr);
      return (addr == ref_addr) && (qty == 16'h0001);
   endfunction

   logic [1:0]  mode_sync_q;
   logic [1:0]  mode_sync_d;
   logic [1:0]  inv_sync_q;
   logic [1:0]  inv_sync_d;
   logic [3:0]  pin_sync;
   logic [3:0]  coil_q;
   logic [3:0]  coil_d;
   logic        rsp_valid_q;
   logic        rsp_valid_d;
   logic [7:0]  rsp_exc_q;
   logic [7:0]  rsp_exc_d;
   logic [15:0] rsp_data_q;
   logic [15:0] rsp_data_d;
   logic        coil_mode;
   logic        invert;
   logic [3:0]  input_state;
   logic [1:0]  sh;
   logic [3:0]  req_mask;
   logic [3:0]  win_mask;
   logic [3:0]  shifted_coils;
   logic [3:0]  shifted_inputs;

   // Configuration levels arrive from outside the clock domain.
   always_comb
   begin
      mode_sync_d = {mode_sync_q[0], coil_mode_en};
      inv_sync_d  = {inv_sync_q[0], input_invert_en};
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_sync_q <= 2'b00;
         inv_sync_q  <= 2'b00;
      end
      else
      begin
         mode_sync_q <= mode_sync_d;
         inv_sync_q  <= inv_sync_d;
      end
   end

   // Each comparator output passes its own two-stage synchroniser.
   for (genvar ch = 0; ch < CHAN_NUM; ch++)
   begin : g_pin_sync
      logic meta_q;
      logic meta_d;
      logic sync_q;
      logic sync_d;

      // Only the second stage reads the first, so no logic sees a settling level.
      always_comb
      begin
         meta_d = input_above_thr[ch];
         sync_d = meta_q;
      end

      always_ff @(posedge mclk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
         end
         else
         begin
            meta_q <= meta_d;
            sync_q <= sync_d;
         end
      end

      assign pin_sync[ch] = sync_q;
   end

   // Switching the option leaves the outputs alone; only the access path changes.
   assign coil_mode   = mode_sync_q[1];
   assign invert      = inv_sync_q[1];
   // The pin already carries the tandem switch level, so no output term is mixed in.
   assign input_state = pin_sync ^ {CHAN_NUM{invert}};

   assign sh             = req_addr[1:0];
   assign req_mask       = chan_mask(req_qty);
   assign win_mask       = req_mask << sh;
   assign shifted_coils  = (coil_q >> sh) & req_mask;
   assign shifted_inputs = (input_state >> sh) & req_mask;

   // Request decode: every request is answered on the next clock.
   always_comb
   begin
      coil_d      = coil_q;
      rsp_valid_d = req_valid;
      rsp_exc_d   = EXC_NONE;
      rsp_data_d  = 16'h0000;
      if (req_valid)
      begin
         case (req_func)
            FN_READ_COILS:
            begin
               if (!coil_mode)
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else if (!span_ok(req_addr, req_qty))
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else
               begin
                  rsp_data_d = {12'h000, shifted_coils};
               end
            end
            // Input reads are legal in both output access modes.
            FN_READ_INPUTS:
            begin
               if (!span_ok(req_addr, req_qty))
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else
               begin
                  rsp_data_d = {12'h000, shifted_inputs};
               end
            end
            FN_READ_HOLDING:
            begin
               if (coil_mode || !one_reg_ok(req_addr, req_qty, OUTPUT_GROUP_REG))
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else
               begin
                  rsp_data_d = {12'h000, coil_q};
               end
            end
            FN_READ_INPUT_REG:
            begin
               if (!one_reg_ok(req_addr, req_qty, PACKED_INPUT_STATES))
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else
               begin
                  rsp_data_d = {12'h000, input_state};
               end
            end
            // Only the exact on and off words are accepted for a single coil.
            FN_FORCE_COIL:
            begin
               if (!coil_mode || req_addr > OUTPUT_COIL_CH3)
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else if (req_wdata == COIL_ON_VALUE)
               begin
                  coil_d[sh] = 1'b1;
                  rsp_data_d = req_wdata;
               end
               else if (req_wdata == COIL_OFF_VALUE)
               begin
                  coil_d[sh] = 1'b0;
                  rsp_data_d = req_wdata;
               end
               else
               begin
                  rsp_exc_d = EXC_ILLEGAL_VALUE;
               end
            end
            // Only the window of addressed coils is rewritten; the others keep their state.
            FN_FORCE_COILS:
            begin
               if (!coil_mode || !span_ok(req_addr, req_qty))
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else
               begin
                  coil_d     = (coil_q & ~win_mask) | ((req_wdata[3:0] << sh) & win_mask);
                  rsp_data_d = req_qty;
               end
            end
            // A grouped write replaces all four outputs, so clients resend the bits they keep.
            FN_PRESET_REG,
            FN_PRESET_REGS:
            begin
               if (coil_mode || req_addr != OUTPUT_GROUP_REG)
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else if (req_func == FN_PRESET_REGS && req_qty != 16'h0001)
               begin
                  rsp_exc_d = EXC_ILLEGAL_ADDR;
               end
               else if ((req_wdata & ~GROUP_VALID_MASK) != 16'h0000)
               begin
                  rsp_exc_d = EXC_ILLEGAL_VALUE;
               end
               else
               begin
                  coil_d     = req_wdata[3:0];
                  rsp_data_d = req_wdata;
               end
            end
            default:
            begin
               rsp_exc_d = EXC_ILLEGAL_FUNC;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         coil_q      <= COIL_RESET;
         rsp_valid_q <= 1'b0;
         rsp_exc_q   <= EXC_NONE;
         rsp_data_q  <= 16'h0000;
      end
      else
      begin
         coil_q      <= coil_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_exc_q   <= rsp_exc_d;
         rsp_data_q  <= rsp_data_d;
      end
   end

   // Outputs are driven both ways at all times, so they never float.
   assign output_on = coil_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_exc   = rsp_exc_q;
   assign rsp_data  = rsp_data_q;

endmodule // dio_map

`default_nettype wire

// file: dio_map_properties.sv
// Concurrent checks on the ports of the discrete I/O map.
`timescale 1ns/1ps
`default_nettype none

module dio_map_properties
   import dio_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        coil_mode_en,
   input wire logic        input_invert_en,
   input wire logic [3:0]  input_above_thr,
   input wire logic [3:0]  output_on,
   input wire logic        req_valid,
   input wire logic [7:0]  req_func,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_qty,
   input wire logic [15:0] req_wdata,
   input wire logic        rsp_valid,
   input wire logic [7:0]  rsp_exc,
   input wire logic [15:0] rsp_data
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_ok;
      rsp_valid && rsp_exc == EXC_NONE;
   endsequence
   property p_answer; req_valid |=> rsp_valid; endproperty
   a_answer: assert property (p_answer) else $error("no answer after request");
   property p_only; rsp_valid |-> $past(req_valid); endproperty
   a_only: assert property (p_only) else $error("answer without request");
   property p_idle; !rsp_valid |-> rsp_exc == EXC_NONE && rsp_data == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("response fields not cleared");
   property p_unsup;
      req_valid && !(req_func inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10})
      |=> rsp_exc == EXC_ILLEGAL_FUNC;
   endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported code not refused");
   property p_reset_off; disable iff (1'b0) !rst_n |-> output_on == COIL_RESET; endproperty
   a_reset_off: assert property (p_reset_off) else $error("outputs not off in reset");
   property p_cause; !$stable(output_on) |-> s_ok; endproperty
   a_cause: assert property (p_cause) else $error("outputs moved without a write");
   property p_force;
      s_ok and $past(req_func) == FN_FORCE_COIL
      |-> output_on[$past(req_addr[1:0])] == ($past(req_wdata) == COIL_ON_VALUE);
   endproperty
   a_force: assert property (p_force) else $error("forced coil state wrong");
   property p_group; s_ok and $past(req_func) == FN_PRESET_REG |-> output_on == $past(req_wdata[3:0]);
   endproperty
   a_group: assert property (p_group) else $error("grouped write wrong");
   property p_inreg; s_ok and $past(req_func) == FN_READ_INPUT_REG |-> rsp_data[15:4] == 12'h000;
   endproperty
   a_inreg: assert property (p_inreg) else $error("packed input upper bits set");
endmodule // dio_map_properties

bind dio_map dio_map_properties i_dio_map_properties (.*);

`default_nettype wire

// file: dio_field.sv
// Field wiring model: pulled-down input pins shared with tandem outputs.
`timescale 1ns/1ps
`default_nettype none

module dio_field
(
   input  wire logic [3:0] field_high,
   input  wire logic [3:0] output_on,
   output var  logic [3:0] input_above_thr
);
   // A pin reads high when the field drives it or its own tandem switch sources it.
   always_comb input_above_thr = field_high | output_on;
endmodule // dio_field

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the discrete I/O map.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import dio_pkg::*;
   logic mclk = 1'b0, cm = 1'b0, inv = 1'b0, rv = 1'b0;
   logic rst_n;
   logic [3:0] fh = 4'h0, thr, oo;
   logic [7:0] rf = 8'h00, ex;
   logic [15:0] ra = 16'h0000, rq = 16'h0000, rw = 16'h0000, dt;
   logic rsv;
   int num_errors = 0, n_checks = 0;
   always #5 mclk = ~mclk;
   dio_field i_dio_field (.field_high(fh), .output_on(oo), .input_above_thr(thr));
   dio_map i_dio_map (.mclk(mclk), .rst_n(rst_n), .coil_mode_en(cm), .input_invert_en(inv),
      .input_above_thr(thr), .output_on(oo), .req_valid(rv), .req_func(rf), .req_addr(ra),
      .req_qty(rq), .req_wdata(rw), .rsp_valid(rsv), .rsp_exc(ex), .rsp_data(dt));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic req(input logic [7:0] f, input logic [15:0] a, q, w);
      @(posedge mclk);
      rv <= 1'b1; rf <= f; ra <= a; rq <= q; rw <= w;
      @(posedge mclk);
      rv <= 1'b0;
      #1;
      chk("rsp_valid", {15'h0, rsv}, 16'h0001);
   endtask
   task automatic cfg(input logic m, input logic i, input logic [3:0] f);
      @(posedge mclk);
      cm <= m; inv <= i; fh <= f;
      repeat (4) @(posedge mclk);
   endtask
   task automatic t_coils;
      cfg(1'b1, 1'b0, 4'h0);
      req(FN_FORCE_COILS, 16'h0001, 16'h0002, 16'h0003);
      chk("mc data", dt, 16'h0002);
      chk("mc out", {12'h0, oo}, 16'h0006);
      req(FN_FORCE_COIL, 16'h0003, 16'h0000, COIL_ON_VALUE);
      chk("sc echo", dt, COIL_ON_VALUE);
      req(FN_FORCE_COIL, 16'h0001, 16'h0000, COIL_OFF_VALUE);
      chk("sc out", {12'h0, oo}, 16'h000C);
      cfg(1'b1, 1'b1, 4'h0);
      req(FN_READ_COILS, 16'h0001, 16'h0003, 16'h0000);
      chk("rc data", dt, 16'h0006);
      chk("inv out", {12'h0, oo}, 16'h000C);
      req(FN_PRESET_REG, 16'h0000, 16'h0001, 16'h0001);
      chk("grp in coil", {8'h0, ex}, {8'h0, EXC_ILLEGAL_ADDR});
      req(FN_FORCE_COIL, 16'h0000, 16'h0000, 16'h1234);
      chk("bad val", {8'h0, ex}, {8'h0, EXC_ILLEGAL_VALUE});
      req(FN_FORCE_COIL, 16'h0004, 16'h0000, COIL_ON_VALUE);
      chk("bad addr", {8'h0, ex}, {8'h0, EXC_ILLEGAL_ADDR});
      chk("kept", {12'h0, oo}, 16'h000C);
   endtask
   task automatic t_group;
      cfg(1'b0, 1'b0, 4'h0);
      req(FN_READ_COILS, 16'h0000, 16'h0001, 16'h0000);
      chk("coil off", {8'h0, ex}, {8'h0, EXC_ILLEGAL_ADDR});
      req(FN_PRESET_REG, 16'h0000, 16'h0001, 16'h0005);
      chk("grp6", {12'h0, oo}, 16'h0005);
      req(FN_PRESET_REGS, 16'h0000, 16'h0001, 16'h000A);
      chk("grp10", {12'h0, oo}, 16'h000A);
      req(FN_READ_HOLDING, 16'h0000, 16'h0001, 16'h0000);
      chk("rd grp", dt, 16'h000A);
      req(FN_PRESET_REG, 16'h0000, 16'h0001, 16'h0010);
      chk("grp bad", {8'h0, ex}, {8'h0, EXC_ILLEGAL_VALUE});
      chk("grp kept", {12'h0, oo}, 16'h000A);
      req(FN_FORCE_COIL, 16'h0000, 16'h0000, COIL_ON_VALUE);
      chk("force grp", {8'h0, ex}, {8'h0, EXC_ILLEGAL_ADDR});
      chk("force kept", {12'h0, oo}, 16'h000A);
      req(8'h11, 16'h0000, 16'h0000, 16'h0000);
      chk("unsup", {8'h0, ex}, {8'h0, EXC_ILLEGAL_FUNC});
   endtask
   task automatic t_inputs;
      req(FN_PRESET_REG, 16'h0000, 16'h0001, 16'h0000);
      cfg(1'b0, 1'b0, 4'hA);
      req(FN_READ_INPUTS, 16'h0001, 16'h0002, 16'h0000);
      chk("in rd", dt, 16'h0001);
      req(FN_READ_INPUT_REG, 16'h0000, 16'h0001, 16'h0000);
      chk("in reg", dt, 16'h000A);
      cfg(1'b0, 1'b1, 4'hA);
      req(FN_READ_INPUT_REG, 16'h0000, 16'h0001, 16'h0000);
      chk("in inv", dt, 16'h0005);
      cfg(1'b0, 1'b0, 4'hA);
      req(FN_PRESET_REG, 16'h0000, 16'h0001, 16'h0001);
      repeat (3) @(posedge mclk);
      req(FN_READ_INPUT_REG, 16'h0000, 16'h0001, 16'h0000);
      chk("tandem", dt, 16'h000B);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      // Going from unknown to low is a falling edge, so the outputs clear at once.
      rst_n <= 1'b0;
      repeat (16) @(posedge mclk);
      chk("reset out", {12'h0, oo}, 16'h0000);
      rst_n <= 1'b1;
      t_coils();
      t_group();
      t_inputs();
      report_and_stop();
   end
endmodule // testbench

`default_nettype wire
